// *** hw/acw_decoder.sv ***
// converter control word decoder: control register, sequencer, power and mux select
// assumes i_clk is the system clock; the serial link runs on its own clock i_sclk
//
// Behaviour
// - write bit set loads the channel, power, range and coding bits into the control register.
// - write bit clear discards the word, all fields unchanged.
// - channel bits take effect at conversion end, select next transfer's input.
// - channel pair decodes as binary index zero to three.
// - multiplexer switches to the next channel on the fourteenth falling edge.
// - channel index of result is sent ahead of twelve result bits.
// - in consecutive sequence mode channel bits give the last channel.
// - sequencer bits ten and three together choose sequencer mode.
// - power mode eleven keeps the device fully powered.
// - power mode ten powers down, keeps register, until field rewritten.
// - power mode zero one shuts down after each conversion once updated.
// - bit one selects input span: zero double reference, one reference.
// - bit zero selects coding: zero twos complement, one straight binary.
// - only first twelve falling edges after chip select load bits.
// - sequencer high bit zero disables sequencing, channel from previous write.
// - sequencer bits one zero update fields without ending a running sequence.
// - both sequencer bits one convert channel zero up to final, repeating.
module acw_decoder
  import acw_pkg::*;
(
  // system clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // serial link
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_din,
  output logic             o_dout,
  // conversion result from the analog core
  input  wire logic [11:0] i_result,
  // decoded controls to the analog core
  output logic [1:0]       o_mux_chan,
  output logic             o_powered,
  output logic             o_range_ref,
  output logic             o_coding_binary,
  output logic             o_seq_active,
  output logic             o_awake
);

  acw_xfer_if xfer ();

  acw_serial_link u_link (
    .i_sclk   (i_sclk),
    .i_cs_n   (i_cs_n),
    .i_din    (i_din),
    .o_dout   (o_dout),
    .i_result (i_result),
    .xfer     (xfer.link)
  );

  // crossings
  logic [2:0]  word_tgl_sync_reg;
  logic [2:0]  mux_tgl_sync_reg;
  logic [2:0]  cs_sync_reg;
  logic        word_evt;
  logic        mux_evt;
  logic [WORD_BITS-1:0] word_cap_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      word_tgl_sync_reg <= 3'h0;
      mux_tgl_sync_reg  <= 3'h0;
      cs_sync_reg       <= 3'h7;
    end
    else
    begin
      word_tgl_sync_reg <= {word_tgl_sync_reg[1:0], xfer.word_tgl};
      mux_tgl_sync_reg  <= {mux_tgl_sync_reg[1:0], xfer.mux_tgl};
      cs_sync_reg       <= {cs_sync_reg[1:0], i_cs_n};
    end
  end

  assign word_evt = word_tgl_sync_reg[2] ^ word_tgl_sync_reg[1];
  assign mux_evt  = mux_tgl_sync_reg[2] ^ mux_tgl_sync_reg[1];

  // word is stable long after its toggle; sample it once the toggle has synchronised
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      word_cap_reg <= 12'h000;
    else if (word_evt)
      word_cap_reg <= xfer.word;
  end

  // word_cap_reg is one cycle behind word_evt
  logic word_new_reg;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      word_new_reg <= 1'b0;
    else
      word_new_reg <= word_evt;
  end

  // control register fields
  logic [1:0] chan_reg;
  logic [1:0] pwr_reg;
  logic       range_reg;
  logic       coding_reg;
  logic       wr_ok;

  assign wr_ok = word_new_reg && word_cap_reg[BIT_WRITE];

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      chan_reg   <= CHAN_RESET;
      pwr_reg    <= PWR_RESET;
      range_reg  <= RANGE_RESET;
      coding_reg <= CODING_RESET;
    end
    else if (wr_ok)
    begin
      chan_reg   <= word_cap_reg[BIT_CHAN_HIGH:BIT_CHAN_LOW];
      pwr_reg    <= word_cap_reg[BIT_PWR_HIGH:BIT_PWR_LOW];
      range_reg  <= word_cap_reg[BIT_RANGE];
      coding_reg <= word_cap_reg[BIT_CODING];
    end
  end

  // sequencer: next channel chosen at each conversion end (mux edge)
  logic [1:0] next_chan_reg;
  logic [1:0] sent_chan_reg;
  logic       seq_run_reg;
  logic [1:0] last_chan_reg;
  logic       seq_start_reg;

  // a fresh consecutive sequence begins at channel zero on the next conversion end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      seq_start_reg <= 1'b0;
    else if (wr_ok && word_cap_reg[BIT_SEQ_HIGH] && word_cap_reg[BIT_SEQ_LOW])
      seq_start_reg <= 1'b1;
    else if (mux_evt)
      seq_start_reg <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      seq_run_reg   <= 1'b0;
      last_chan_reg <= CHAN_RESET;
    end
    else if (wr_ok)
    begin
      unique case (acw_seq_e'({word_cap_reg[BIT_SEQ_HIGH], word_cap_reg[BIT_SEQ_LOW]}))
        ACW_SEQ_RUN:
        begin
          seq_run_reg   <= 1'b1;
          last_chan_reg <= word_cap_reg[BIT_CHAN_HIGH:BIT_CHAN_LOW];
        end
        ACW_SEQ_KEEP: seq_run_reg <= seq_run_reg;
        default:      seq_run_reg <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      next_chan_reg <= CHAN_RESET;
      sent_chan_reg <= CHAN_RESET;
    end
    else
    begin
      // copy of the channel now at the mux, reported with the next frame's result
      sent_chan_reg <= next_chan_reg;
      if (mux_evt)
      begin
        if (seq_run_reg && seq_start_reg)
          next_chan_reg <= 2'h0;
        else if (seq_run_reg)
          next_chan_reg <= (next_chan_reg == last_chan_reg) ? 2'h0 : next_chan_reg + 2'h1;
        else
          next_chan_reg <= chan_reg;
      end
    end
  end

  // the channel index is reported for the conversion that the next frame returns
  assign xfer.sent_chan = sent_chan_reg;

  // power: auto shutdown after a conversion, wake on chip select falling
  logic                   asleep_reg;
  logic [5:0]             wake_cnt_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      asleep_reg <= 1'b0;
    else if (pwr_reg == ACW_PWR_AUTO && mux_evt)
      asleep_reg <= 1'b1;
    else if (cs_sync_reg[2:1] == 2'b10 || pwr_reg != ACW_PWR_AUTO)
      asleep_reg <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      wake_cnt_reg <= 6'h00;
    else if (asleep_reg || pwr_reg == ACW_PWR_OFF)
      wake_cnt_reg <= 6'(WAKE_CYCLES);
    else if (wake_cnt_reg != 6'h00)
      wake_cnt_reg <= wake_cnt_reg - 6'h01;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_mux_chan      <= CHAN_RESET;
      o_powered       <= 1'b1;
      o_range_ref     <= RANGE_RESET;
      o_coding_binary <= CODING_RESET;
      o_seq_active    <= 1'b0;
      o_awake         <= 1'b1;
    end
    else
    begin
      o_mux_chan      <= next_chan_reg;
      o_powered       <= (pwr_reg == ACW_PWR_NORMAL) ||
                         (pwr_reg == ACW_PWR_INVALID) ||
                         (pwr_reg == ACW_PWR_AUTO && !asleep_reg);
      o_range_ref     <= range_reg;
      o_coding_binary <= coding_reg;
      o_seq_active    <= seq_run_reg;
      o_awake         <= (wake_cnt_reg == 6'h00) && !asleep_reg && (pwr_reg != ACW_PWR_OFF);
    end
  end

  // assertions
  sequence s_write_seen;
    word_new_reg && word_cap_reg[BIT_WRITE];
  endsequence

  write_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_write_seen |=> chan_reg == $past(word_cap_reg[BIT_CHAN_HIGH:BIT_CHAN_LOW]))
    else $error("channel field not loaded");

  write_block_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (word_new_reg && !word_cap_reg[BIT_WRITE]) |=> $stable(pwr_reg) && $stable(chan_reg))
    else $error("field changed without write bit");

  full_power_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (pwr_reg == ACW_PWR_NORMAL) [*2] |-> o_powered)
    else $error("not powered in normal mode");

  shutdown_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (pwr_reg == ACW_PWR_OFF) [*2] |-> !o_powered && !o_awake)
    else $error("powered in full shutdown");

  auto_sleep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (pwr_reg == ACW_PWR_AUTO && mux_evt) |=> ##1 !o_powered)
    else $error("no auto shutdown after conversion");

  range_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_write_seen |=> ##1 o_range_ref == $past(word_cap_reg[BIT_RANGE], 2))
    else $error("range output wrong");

  coding_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_write_seen |=> ##1 o_coding_binary == $past(word_cap_reg[BIT_CODING], 2))
    else $error("coding output wrong");

  seq_wrap_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (mux_evt && seq_run_reg && next_chan_reg == last_chan_reg) |=> next_chan_reg == 2'h0)
    else $error("sequence did not wrap to channel zero");

  seq_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_write_seen and (word_cap_reg[BIT_SEQ_HIGH] && !word_cap_reg[BIT_SEQ_LOW]))
      |=> seq_run_reg == $past(seq_run_reg))
    else $error("sequence ended by keep write");

  seq_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_write_seen and !word_cap_reg[BIT_SEQ_HIGH]) |=> !seq_run_reg)
    else $error("sequence still running");

  // a conversion end as seen in the system domain
  sequence s_conv_end;
    mux_evt;
  endsequence

  seq_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_conv_end and (seq_run_reg && seq_start_reg)) |=> next_chan_reg == 2'h0)
    else $error("sequence did not start at channel zero");

  seq_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_conv_end and (seq_run_reg && !seq_start_reg && next_chan_reg != last_chan_reg))
      |=> next_chan_reg == $past(next_chan_reg) + 2'h1)
    else $error("sequence did not step to the next channel");

  chan_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_conv_end and !seq_run_reg) |=> next_chan_reg == $past(chan_reg))
    else $error("next channel not taken from the last write");

  mux_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_conv_end |=> ##1 o_mux_chan == $past(next_chan_reg))
    else $error("mux output does not follow the next channel");

  sleep_awake_a: assert property (@(posedge i_clk) disable iff (i_rst)
    asleep_reg |=> !o_awake)
    else $error("awake while asleep");

endmodule

// *** hw/acw_pkg.sv ***
// package for the converter control word decoder: field positions, encodings, timing
// assumes a serial master frames each transfer with chip select and a free serial clock
package acw_pkg;

  localparam int unsigned WORD_BITS        = 12;
  localparam int unsigned FRAME_BITS       = 16;
  localparam logic [4:0]  LOAD_EDGES       = 5'h0C;
  localparam logic [4:0]  MUX_EDGE         = 5'h0E;

  localparam int unsigned BIT_WRITE        = 11;
  localparam int unsigned BIT_SEQ_HIGH     = 10;
  localparam int unsigned BIT_CHAN_HIGH    = 7;
  localparam int unsigned BIT_CHAN_LOW     = 6;
  localparam int unsigned BIT_PWR_HIGH     = 5;
  localparam int unsigned BIT_PWR_LOW      = 4;
  localparam int unsigned BIT_SEQ_LOW      = 3;
  localparam int unsigned BIT_RANGE        = 1;
  localparam int unsigned BIT_CODING       = 0;

  localparam logic [1:0]  CHAN_RESET       = 2'h0;
  localparam logic [1:0]  PWR_RESET        = 2'h3;
  localparam logic        RANGE_RESET      = 1'h0;
  localparam logic        CODING_RESET     = 1'h0;
  localparam logic [1:0]  SEQ_RESET        = 2'h0;

  // wake-up interval after full or automatic shutdown
  localparam int unsigned WAKE_NS          = 1000;
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned WAKE_CYCLES      = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ACW_PWR_INVALID = 2'b00,
    ACW_PWR_AUTO    = 2'b01,
    ACW_PWR_OFF     = 2'b10,
    ACW_PWR_NORMAL  = 2'b11
  } acw_pwr_e;

  typedef enum logic [1:0] {
    ACW_SEQ_OFF     = 2'b00,
    ACW_SEQ_KEEP    = 2'b10,
    ACW_SEQ_RUN     = 2'b11
  } acw_seq_e;

endpackage

// *** hw/acw_serial_link.sv ***
// serial-clock domain: shifts the control word in, shifts channel index and result out
// assumes the serial clock idles between frames; chip select low frames a transfer
module acw_serial_link
  import acw_pkg::*;
(
  // serial pins
  input  wire logic              i_sclk,
  input  wire logic              i_cs_n,
  input  wire logic              i_din,
  output logic                   o_dout,
  // result word to send
  input  wire logic [11:0]       i_result,
  // crossing to system domain
  acw_xfer_if.link               xfer
);

  logic [4:0]             edge_cnt_reg;
  logic [WORD_BITS-1:0]   shift_reg;
  logic [WORD_BITS-1:0]   word_reg;
  // power-up value only: the serial domain has no reset of its own
  logic                   word_tgl_reg = 1'b0;
  logic                   mux_tgl_reg  = 1'b0;
  logic [15:0]            out_reg;
  logic                   dout_reg;

  assign xfer.word     = word_reg;
  assign xfer.word_tgl = word_tgl_reg;
  assign xfer.mux_tgl  = mux_tgl_reg;
  assign o_dout        = dout_reg;

  // counts falling edges inside a frame; the count restarts with each frame
  always_ff @(negedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
      edge_cnt_reg <= 5'h00;
    else if (edge_cnt_reg != 5'h1F)
      edge_cnt_reg <= edge_cnt_reg + 5'h01;
  end

  // only the first twelve falling edges load bits
  always_ff @(negedge i_sclk)
  begin
    if (!i_cs_n && edge_cnt_reg < LOAD_EDGES)
      shift_reg <= {shift_reg[WORD_BITS-2:0], i_din};
  end

  // on the twelfth edge the full word is handed over by a toggle
  always_ff @(negedge i_sclk)
  begin
    if (!i_cs_n && edge_cnt_reg == LOAD_EDGES - 5'h01)
    begin
      word_reg     <= {shift_reg[WORD_BITS-2:0], i_din};
      word_tgl_reg <= ~word_tgl_reg;
    end
    if (!i_cs_n && edge_cnt_reg == MUX_EDGE - 5'h01)
      mux_tgl_reg <= ~mux_tgl_reg;
  end

  // two zeros, channel index, then twelve result bits, on falling edges
  always_ff @(negedge i_sclk)
  begin
    if (!i_cs_n && edge_cnt_reg == 5'h00)
      out_reg <= {2'b00, xfer.sent_chan, i_result};
    else if (!i_cs_n)
      out_reg <= {out_reg[14:0], 1'b0};
  end

  always_ff @(negedge i_sclk)
  begin
    dout_reg <= (edge_cnt_reg == 5'h00) ? 1'b0 : out_reg[14];
  end

endmodule

// *** hw/acw_xfer_if.sv ***
// interface carrying a captured control word from the serial domain to the system domain
// assumes the serial side toggles word_tgl once per frame and holds word stable after it
interface acw_xfer_if;
  import acw_pkg::*;
  logic [WORD_BITS-1:0] word;
  logic                 word_tgl;
  logic [1:0]           sent_chan;
  logic                 mux_tgl;

  modport link (output word, output word_tgl, input sent_chan, output mux_tgl);
  modport core (input word, input word_tgl, output sent_chan, input mux_tgl);
endinterface

// *** test/acw_host_model.sv ***
// host model: serial master that frames 16-clock transfers
// assumes the device samples din and shifts dout on falling sclk edges
module acw_host_model
(
  // serial pins
  output logic        o_sclk,
  output logic        o_cs_n,
  output logic        o_din,
  input  wire logic   i_dout,
  // captured frame
  output logic        o_done,
  output logic [15:0] o_rx
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_sclk = 1'h1;
    o_cs_n = 1'h1;
    o_din  = 1'h0;
    o_done = 1'h0;
    o_rx   = 16'h0000;
  end

  // w[15:4] is the control word, w[3:0] trails on edges 13 to 16
  task automatic frame(input logic [15:0] w);
    int k;
    #13;
    o_cs_n = 1'h0;
    for (k = 15; k >= 0; k--)
    begin
      o_din = w[k];
      #80;
      o_sclk  = 1'h0;
      #80;
      o_rx[k] = i_dout;
      o_sclk  = 1'h1;
    end
    // clock stands still between frames; released din flips
    o_cs_n = 1'h1;
    o_din  = ~o_din;
    o_done = 1'h1;
    #20;
    o_done = 1'h0;
  endtask
endmodule

// *** test/testbench.sv ***
// testbench: host model frames control words into the decoder
// assumes outputs settle within ten system clocks after a frame ends
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import acw_pkg::*;

  typedef struct packed {
    logic        dchk;
    logic [13:0] dout;
    logic [1:0]  mux;
    logic [3:0]  ctl;
  } acw_exp_s;

  logic        i_clk    = 1'h0;
  logic        i_rst    = 1'h1;
  logic [11:0] i_result = 12'h000;
  logic        sclk, cs_n, din, dout, done, pwr, rng, cod, seq, awake;
  logic [1:0]  mux;
  logic [15:0] rx;
  int          fails      = 0;
  int          num_checks = 0;
  int          seed       = 32'h40ED;
  acw_exp_s    expq[$];
  acw_exp_s    mon_e;
  logic [1:0]  e_ch    = CHAN_RESET;
  logic [1:0]  e_pm    = PWR_RESET;
  logic        e_rg    = RANGE_RESET;
  logic        e_cd    = CODING_RESET;
  logic        e_sq    = 1'h0;
  logic [1:0]  e_nx    = CHAN_RESET;
  logic [1:0]  e_last  = CHAN_RESET;
  logic        started = 1'h0;

  always #10 i_clk = ~i_clk;

  acw_decoder u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_din(din), .o_dout(dout), .i_result(i_result), .o_mux_chan(mux), .o_powered(pwr),
    .o_range_ref(rng), .o_coding_binary(cod), .o_seq_active(seq), .o_awake(awake));

  acw_host_model u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout),
    .o_done(done), .o_rx(rx));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one transfer with random spare, range, coding and trailing bits
  task automatic send(input logic wr, input logic [1:0] sm, input logic [1:0] ch,
                      input logic [1:0] pm);
    logic [15:0] w;
    acw_exp_s    e;
    w        = 16'($random(seed));
    w[15]    = wr;
    w[14]    = sm[1];
    w[11:10] = ch;
    w[9:8]   = pm;
    w[7]     = sm[0];
    @(posedge i_clk);
    #2 i_result = 12'($random(seed));
    e.dchk = started;
    e.dout = {e_nx, i_result};
    if (wr)
    begin
      e_rg = w[5];
      e_cd = w[4];
      e_pm = pm;
      e_sq = sm[1] ? (sm[0] | e_sq) : 1'h0;
      if (!sm[1])
        e_ch = ch;
      if (sm == 2'h3)
        e_last = ch;
    end
    // channel the mux takes at this frame's fourteenth edge
    if (!e_sq)
      e_nx = e_ch;
    else if (wr && sm == 2'h3)
      e_nx = 2'h0;
    else
      e_nx = (e_nx == e_last) ? 2'h0 : e_nx + 2'h1;
    e.mux  = e_nx;
    e.ctl  = {e_pm == 2'h3, e_rg, e_cd, e_sq};
    expq.push_back(e);
    started = 1'h1;
    u_host.frame(w);
    // gap exceeds the wake-up interval before the next conversion
    repeat (60) @(posedge i_clk);
  endtask

  always @(posedge done)
  begin
    repeat (10) @(posedge i_clk);
    mon_e = expq.pop_front();
    if (mon_e.dchk)
      check(rx, {2'h0, mon_e.dout});
    check({14'h0000, mux}, {14'h0000, mon_e.mux});
    check({12'h000, pwr, rng, cod, seq}, {12'h000, mon_e.ctl});
  end

  initial
  begin
    repeat (8) @(posedge i_clk);
    #2 i_rst = 1'h0;
    repeat (4) @(posedge i_clk);
    // power mode 00 is never sent
    for (int c = 0; c < 4; c++)
      send(1'h1, 2'h0, c[1:0], 2'h3);
    send(1'h0, 2'h3, 2'h1, 2'h2);
    send(1'h1, 2'h0, 2'h2, 2'h2);
    send(1'h0, 2'h0, 2'h3, 2'h3);
    send(1'h1, 2'h0, 2'h1, 2'h1);
    send(1'h1, 2'h3, 2'h1, 2'h3);
    send(1'h1, 2'h2, 2'h0, 2'h3);
    send(1'h1, 2'h2, 2'h3, 2'h3);
    send(1'h1, 2'h0, 2'h2, 2'h3);
    send(1'h1, 2'h1, 2'h1, 2'h3);
    repeat (60) @(posedge i_clk);
    check({15'h0000, awake}, 16'h0001);
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge i_clk);
    fails++;
    complete_run();
  end
endmodule
